/* rtl/clk_switch_pkg.sv */
// package: register map, field positions, reset values and timing counts of the clock switch
package clk_switch_pkg;

  // ---------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] SUBSYSTEM_CLOCK_SELECT_OFS = 8'h00;
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CLOCK_STATUS_CONTROL_OFS = 8'h08;
  localparam logic [7:0] CLOCK_MODE_CONTROL_OFS = 8'h0c;
  localparam logic [7:0] OSC_STAB_TIME_SELECT_OFS = 8'h10;
  localparam logic [7:0] OSC_STAB_COUNTER_STATUS_OFS = 8'h14;
  localparam logic [7:0] SUBCLOCK_SUPPLY_MODE_OFS = 8'h18;

  // ---------------------------------------------------------------
  // subsystem clock select fields
  // ---------------------------------------------------------------
  localparam int LOW_SPEED_OSC_SELECT_BIT = 0;

  // ---------------------------------------------------------------
  // system clock control fields
  // ---------------------------------------------------------------
  localparam int CPU_CLOCK_STATUS_BIT = 7;
  localparam int CPU_CLOCK_SOURCE_SELECT_BIT = 6;
  localparam int MAIN_CLOCK_STATUS_BIT = 5;
  localparam int MAIN_CLOCK_SELECT_BIT = 4;
  localparam int ON_CHIP_CLOCK_STATUS_BIT = 1;
  localparam int ON_CHIP_CLOCK_SELECT_BIT = 0;

  // ---------------------------------------------------------------
  // clock status control fields
  // ---------------------------------------------------------------
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int SUB_OSC_STOP_BIT = 6;
  localparam int MID_SPEED_OSC_ENABLE_BIT = 1;
  localparam int HIGH_SPEED_OSC_STOP_BIT = 0;

  // ---------------------------------------------------------------
  // clock mode control fields
  // ---------------------------------------------------------------
  localparam int EXTERNAL_MAIN_CLOCK_BIT = 7;
  localparam int MAIN_OSC_MODE_BIT = 6;
  localparam int EXTERNAL_SUBCLOCK_BIT = 5;
  localparam int SUB_OSC_MODE_BIT = 4;
  localparam int SUB_OSC_DRIVE_HI_BIT = 2;
  localparam int SUB_OSC_DRIVE_LO_BIT = 1;
  localparam int MAIN_OSC_HIGH_GAIN_BIT = 0;

  // ---------------------------------------------------------------
  // subclock supply mode fields
  // ---------------------------------------------------------------
  localparam int LOW_POWER_SUB_SUPPLY_BIT = 7;
  localparam int INTERVAL_TIMER_CLOCK_SELECT_BIT = 4;

  // ---------------------------------------------------------------
  // writable masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SUBSYSTEM_CLOCK_SELECT_MASK = 8'h01;
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_MASK = 8'h51;
  localparam logic [7:0] CLOCK_STATUS_CONTROL_MASK = 8'hc3;
  localparam logic [7:0] CLOCK_MODE_CONTROL_MASK = 8'hf7;
  localparam logic [7:0] OSC_STAB_TIME_SELECT_MASK = 8'h07;
  localparam logic [7:0] SUBCLOCK_SUPPLY_MODE_MASK = 8'h90;
  localparam logic [7:0] SUBSYSTEM_CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] SYSTEM_CLOCK_CONTROL_RST = 8'h00;
  localparam logic [7:0] CLOCK_STATUS_CONTROL_RST = 8'hc0;
  localparam logic [7:0] CLOCK_MODE_CONTROL_RST = 8'h00;
  localparam logic [7:0] OSC_STAB_TIME_SELECT_RST = 8'h07;
  localparam logic [7:0] SUBCLOCK_SUPPLY_MODE_RST = 8'h00;

  // ---------------------------------------------------------------
  // timing: main crystal stabilisation counter and switch delay
  // ---------------------------------------------------------------
  localparam int STAB_COUNT_WIDTH = 19;
  localparam int SWITCH_SYNC_CYCLES = 4;
  localparam logic [2:0] STAB_TIME_SEL_WIDEST = 3'h7;

  // ---------------------------------------------------------------
  // active cpu/peripheral clock source
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_HIGH_SPEED = 2'b00,
    SRC_MID_SPEED = 2'b01,
    SRC_MAIN_OSC = 2'b10,
    SRC_SUBSYSTEM = 2'b11
  } clk_src_e;

endpackage

/* rtl/clk_switch_tracker.sv */
// module: status tracker that follows a clock select once the target clock runs
`timescale 1ns/1ps
module clk_switch_tracker
  import clk_switch_pkg::*;
#(
  parameter int SYNC_CYCLES = SWITCH_SYNC_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic target_ok_i,
  output logic status_o
);

  localparam int CW = $clog2(SYNC_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SYNC_CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic status_nxt;
  wire pending = (req_i != status_o) && target_ok_i;
  wire done = pending && (cnt_r == LAST);

  // -------------------------------------------------------------
  // a switch waits for a running target, so a dead clock never stalls the cpu
  // -------------------------------------------------------------
  assign cnt_nxt = done ? '0 : (pending ? cnt_r + CW'(1) : '0);
  assign status_nxt = done ? req_i : status_o;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      status_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      status_o <= status_nxt;
    end
  end

endmodule

/* rtl/cpu_clock_source_switch.sv */
// module: cpu clock source switch with oscillator control and avalon register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - low-speed select bit starts low-speed oscillator
// - source select bit picks subsystem clock
// - cpu status bit shows subsystem clock running
// - mid-speed enable bit runs or stops oscillator
// - main mode bits pick crystal or external
// - three-bit field picks main stabilisation time
// - clearing main stop bit starts main oscillator
// - counter status reports elapsed main stabilisation
// - main select bit picks high-speed system clock
// - main status bit shows high-speed system clock
// - timer select bit clocks interval timer low-speed
// - low-power bit limits subsystem clock in standby
// - sub mode bits pick sub crystal or external
// - clearing sub stop bit starts sub oscillator
// - high-speed stop bit stops on-chip oscillator
// - on-chip select picks mid or high speed
module cpu_clock_source_switch
  import clk_switch_pkg::*;
#(
  parameter int SYNC_CYCLES = SWITCH_SYNC_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic MAIN_OSC_TICK_I,
  input wire logic STANDBY_I,
  output logic HIGH_SPEED_OSC_EN_O,
  output logic MID_SPEED_OSC_EN_O,
  output logic LOW_SPEED_OSC_EN_O,
  output logic MAIN_CRYSTAL_OSC_EN_O,
  output logic EXTERNAL_MAIN_CLOCK_O,
  output logic MAIN_OSC_HIGH_GAIN_O,
  output logic SUB_CRYSTAL_OSC_EN_O,
  output logic EXTERNAL_SUBCLOCK_O,
  output logic [1:0] SUB_OSC_DRIVE_O,
  output logic [1:0] CPU_PERIPHERAL_CLOCK_SRC_O,
  output logic SUBSYSTEM_USES_LOW_SPEED_O,
  output logic INTERVAL_TIMER_LOW_SPEED_O,
  output logic RTC_SUB_CLK_EN_O,
  output logic TIMER_SUB_CLK_EN_O,
  output logic PERIPH_SUB_CLK_EN_O
);

  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_sync1_r;
  logic rst_n;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_sync1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n <= rst_sync1_r;
    end
  end

  // -------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------
  logic [7:0] sub_sel_r;
  logic [7:0] sys_ctl_r;
  logic [7:0] stat_ctl_r;
  logic [7:0] mode_ctl_r;
  logic [7:0] stab_sel_r;
  logic [7:0] supply_r;
  logic [STAB_COUNT_WIDTH-1:0] stab_cnt_r;
  logic [STAB_COUNT_WIDTH-1:0] stab_cnt_nxt;
  logic cpu_clock_status;
  logic main_clock_status;
  logic on_chip_clock_status;

  // -------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer edge
  // -------------------------------------------------------------
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  wire req = AVS_READ_I || AVS_WRITE_I;
  wire wr_take = AVS_WRITE_I && ack_r && AVS_BYTEENABLE_I[0];
  wire rd_fetch = req && !ack_r;
  wire [7:0] wd = AVS_WRITEDATA_I[7:0];

  wire sel_sub = (AVS_ADDRESS_I == SUBSYSTEM_CLOCK_SELECT_OFS);
  wire sel_sys = (AVS_ADDRESS_I == SYSTEM_CLOCK_CONTROL_OFS);
  wire sel_stat = (AVS_ADDRESS_I == CLOCK_STATUS_CONTROL_OFS);
  wire sel_mode = (AVS_ADDRESS_I == CLOCK_MODE_CONTROL_OFS);
  wire sel_stsel = (AVS_ADDRESS_I == OSC_STAB_TIME_SELECT_OFS);
  wire sel_stcnt = (AVS_ADDRESS_I == OSC_STAB_COUNTER_STATUS_OFS);
  wire sel_supply = (AVS_ADDRESS_I == SUBCLOCK_SUPPLY_MODE_OFS);

  // -------------------------------------------------------------
  // field views
  // -------------------------------------------------------------
  wire low_speed_osc_select = sub_sel_r[LOW_SPEED_OSC_SELECT_BIT];
  wire cpu_clock_source_select = sys_ctl_r[CPU_CLOCK_SOURCE_SELECT_BIT];
  wire main_clock_select = sys_ctl_r[MAIN_CLOCK_SELECT_BIT];
  wire on_chip_clock_select = sys_ctl_r[ON_CHIP_CLOCK_SELECT_BIT];
  wire main_osc_stop = stat_ctl_r[MAIN_OSC_STOP_BIT];
  wire sub_osc_stop = stat_ctl_r[SUB_OSC_STOP_BIT];
  wire mid_speed_osc_enable = stat_ctl_r[MID_SPEED_OSC_ENABLE_BIT];
  wire high_speed_osc_stop = stat_ctl_r[HIGH_SPEED_OSC_STOP_BIT];
  wire external_main_clock = mode_ctl_r[EXTERNAL_MAIN_CLOCK_BIT];
  wire main_osc_mode = mode_ctl_r[MAIN_OSC_MODE_BIT];
  wire external_subclock = mode_ctl_r[EXTERNAL_SUBCLOCK_BIT];
  wire sub_osc_mode = mode_ctl_r[SUB_OSC_MODE_BIT];
  wire low_power_sub_supply = supply_r[LOW_POWER_SUB_SUPPLY_BIT];
  wire interval_timer_clock_select = supply_r[INTERVAL_TIMER_CLOCK_SELECT_BIT];

  // -------------------------------------------------------------
  // oscillator enables
  // -------------------------------------------------------------
  // the timer clock choice keeps the low-speed oscillator alive on its own
  wire ls_run = low_speed_osc_select || interval_timer_clock_select;
  wire ms_run = mid_speed_osc_enable;
  wire hs_run = !high_speed_osc_stop;
  wire main_run = main_osc_mode && !main_osc_stop;
  wire main_ext = main_osc_mode && external_main_clock;
  wire sub_run = sub_osc_mode && !sub_osc_stop;
  wire sub_ext = sub_osc_mode && external_subclock;

  // -------------------------------------------------------------
  // main crystal stabilisation counter
  // -------------------------------------------------------------
  // the counter only counts crystal ticks; an external clock needs no wait
  wire stab_counting = main_run && !main_ext;
  wire [7:0] stab_elapsed_flags = {
    |stab_cnt_r[STAB_COUNT_WIDTH-1:8],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:9],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:10],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:11],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:13],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:15],
    |stab_cnt_r[STAB_COUNT_WIDTH-1:17],
    stab_cnt_r[STAB_COUNT_WIDTH-1]
  };

  // selected wait: 000 -> 2^8 ticks ... 010 -> 2^10 ticks ... 111 -> 2^18 ticks
  wire [2:0] stab_time_sel = stab_sel_r[2:0];
  wire [7:0] stab_flag_rev = {<<{stab_elapsed_flags}};
  wire stab_done = stab_flag_rev[stab_time_sel];
  wire main_ready = main_run && (main_ext || stab_done);

  assign stab_cnt_nxt = !stab_counting ? '0 :
                        (MAIN_OSC_TICK_I && !stab_done) ? stab_cnt_r + STAB_COUNT_WIDTH'(1) :
                        stab_cnt_r;

  // -------------------------------------------------------------
  // source switching trackers
  // -------------------------------------------------------------
  wire on_chip_ok = on_chip_clock_select ? ms_run : hs_run;
  wire onchip_live = on_chip_clock_status ? ms_run : hs_run;
  wire main_ok = main_clock_select ? main_ready : onchip_live;
  wire main_live = main_clock_status ? main_ready : onchip_live;
  // subsystem clock comes from the low-speed oscillator or the sub oscillator
  wire sub_ok = low_speed_osc_select ? ls_run : sub_run;
  wire cpu_ok = cpu_clock_source_select ? sub_ok : main_live;

  clk_switch_tracker #(
    .SYNC_CYCLES(SYNC_CYCLES)
  ) u_on_chip (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .req_i(on_chip_clock_select),
    .target_ok_i(on_chip_ok),
    .status_o(on_chip_clock_status)
  );

  clk_switch_tracker #(
    .SYNC_CYCLES(SYNC_CYCLES)
  ) u_main (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .req_i(main_clock_select),
    .target_ok_i(main_ok),
    .status_o(main_clock_status)
  );

  clk_switch_tracker #(
    .SYNC_CYCLES(SYNC_CYCLES)
  ) u_cpu (
    .clk_i(MCLK_I),
    .rst_n_i(rst_n),
    .req_i(cpu_clock_source_select),
    .target_ok_i(cpu_ok),
    .status_o(cpu_clock_status)
  );

  // -------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------
  logic [7:0] sys_ctl_wd;
  // main select ignores writes while the cpu sits on the subsystem clock
  assign sys_ctl_wd = cpu_clock_status ?
                      ((wd & ~(8'h01 << MAIN_CLOCK_SELECT_BIT)) | (sys_ctl_r & (8'h01 << MAIN_CLOCK_SELECT_BIT))) :
                      wd;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sub_sel_r <= SUBSYSTEM_CLOCK_SELECT_RST;
      sys_ctl_r <= SYSTEM_CLOCK_CONTROL_RST;
      stat_ctl_r <= CLOCK_STATUS_CONTROL_RST;
      mode_ctl_r <= CLOCK_MODE_CONTROL_RST;
      stab_sel_r <= OSC_STAB_TIME_SELECT_RST;
      supply_r <= SUBCLOCK_SUPPLY_MODE_RST;
    end else if (wr_take) begin
      if (sel_sub) sub_sel_r <= wd & SUBSYSTEM_CLOCK_SELECT_MASK;
      if (sel_sys) sys_ctl_r <= sys_ctl_wd & SYSTEM_CLOCK_CONTROL_MASK;
      if (sel_stat) stat_ctl_r <= wd & CLOCK_STATUS_CONTROL_MASK;
      if (sel_mode) mode_ctl_r <= wd & CLOCK_MODE_CONTROL_MASK;
      if (sel_stsel) stab_sel_r <= wd & OSC_STAB_TIME_SELECT_MASK;
      if (sel_supply) supply_r <= wd & SUBCLOCK_SUPPLY_MODE_MASK;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt_r <= '0;
    end else begin
      stab_cnt_r <= stab_cnt_nxt;
    end
  end

  // -------------------------------------------------------------
  // register reads
  // -------------------------------------------------------------
  wire [7:0] sys_ctl_view = {cpu_clock_status, sys_ctl_r[6], main_clock_status,
                             sys_ctl_r[4:2], on_chip_clock_status, sys_ctl_r[0]};

  logic [7:0] rd_byte;
  assign rd_byte = sel_sub ? sub_sel_r :
                   sel_sys ? sys_ctl_view :
                   sel_stat ? stat_ctl_r :
                   sel_mode ? mode_ctl_r :
                   sel_stsel ? stab_sel_r :
                   sel_stcnt ? stab_elapsed_flags :
                   sel_supply ? supply_r :
                   8'h00;
  assign rdata_nxt = rd_fetch ? {24'h000000, rd_byte} : rdata_r;

  // the answer edge follows the fetch edge, so read data never move under the master
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= rd_fetch;
      wait_r <= !rd_fetch;
      rdata_r <= rdata_nxt;
    end
  end

  assign AVS_READDATA_O = rdata_r;
  assign AVS_WAITREQUEST_O = wait_r;

  // -------------------------------------------------------------
  // clock source and supply outputs
  // -------------------------------------------------------------
  clk_src_e src_nxt;
  assign src_nxt = cpu_clock_status ? SRC_SUBSYSTEM :
                   main_clock_status ? SRC_MAIN_OSC :
                   on_chip_clock_status ? SRC_MID_SPEED : SRC_HIGH_SPEED;

  // with the low-power bit set, in standby on the subsystem clock only rtc and interval timer keep it
  wire sub_standby = low_power_sub_supply && cpu_clock_status && STANDBY_I;

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      HIGH_SPEED_OSC_EN_O <= 1'b0;
      MID_SPEED_OSC_EN_O <= 1'b0;
      LOW_SPEED_OSC_EN_O <= 1'b0;
      MAIN_CRYSTAL_OSC_EN_O <= 1'b0;
      EXTERNAL_MAIN_CLOCK_O <= 1'b0;
      MAIN_OSC_HIGH_GAIN_O <= 1'b0;
      SUB_CRYSTAL_OSC_EN_O <= 1'b0;
      EXTERNAL_SUBCLOCK_O <= 1'b0;
      SUB_OSC_DRIVE_O <= 2'h0;
      CPU_PERIPHERAL_CLOCK_SRC_O <= 2'h0;
      SUBSYSTEM_USES_LOW_SPEED_O <= 1'b0;
      INTERVAL_TIMER_LOW_SPEED_O <= 1'b0;
      RTC_SUB_CLK_EN_O <= 1'b0;
      TIMER_SUB_CLK_EN_O <= 1'b0;
      PERIPH_SUB_CLK_EN_O <= 1'b0;
    end else begin
      HIGH_SPEED_OSC_EN_O <= hs_run;
      MID_SPEED_OSC_EN_O <= ms_run;
      LOW_SPEED_OSC_EN_O <= ls_run;
      MAIN_CRYSTAL_OSC_EN_O <= main_run && !main_ext;
      EXTERNAL_MAIN_CLOCK_O <= main_run && main_ext;
      MAIN_OSC_HIGH_GAIN_O <= mode_ctl_r[MAIN_OSC_HIGH_GAIN_BIT];
      SUB_CRYSTAL_OSC_EN_O <= sub_run && !sub_ext;
      EXTERNAL_SUBCLOCK_O <= sub_run && sub_ext;
      SUB_OSC_DRIVE_O <= {mode_ctl_r[SUB_OSC_DRIVE_HI_BIT], mode_ctl_r[SUB_OSC_DRIVE_LO_BIT]};
      CPU_PERIPHERAL_CLOCK_SRC_O <= src_nxt;
      SUBSYSTEM_USES_LOW_SPEED_O <= low_speed_osc_select;
      INTERVAL_TIMER_LOW_SPEED_O <= interval_timer_clock_select;
      RTC_SUB_CLK_EN_O <= sub_ok;
      TIMER_SUB_CLK_EN_O <= sub_ok;
      PERIPH_SUB_CLK_EN_O <= sub_ok && !sub_standby;
    end
  end

endmodule

/* verif/clk_switch_checker_assertions.sv */
// checker on the clock switch ports
`timescale 1ns/1ps
module clk_switch_checker
  import clk_switch_pkg::*;
#(
  parameter int SYNC_CYCLES = SWITCH_SYNC_CYCLES
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic STANDBY_I,
  input wire logic HIGH_SPEED_OSC_EN_O,
  input wire logic MID_SPEED_OSC_EN_O,
  input wire logic LOW_SPEED_OSC_EN_O,
  input wire logic MAIN_CRYSTAL_OSC_EN_O,
  input wire logic EXTERNAL_MAIN_CLOCK_O,
  input wire logic SUB_CRYSTAL_OSC_EN_O,
  input wire logic EXTERNAL_SUBCLOCK_O,
  input wire logic SUBSYSTEM_USES_LOW_SPEED_O,
  input wire logic INTERVAL_TIMER_LOW_SPEED_O,
  input wire logic RTC_SUB_CLK_EN_O,
  input wire logic TIMER_SUB_CLK_EN_O,
  input wire logic PERIPH_SUB_CLK_EN_O
);
  // ------
  // helpers
  // ------
  logic [7:0] csc_d_r;
  wire logic csc_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0] &&
    (AVS_ADDRESS_I == CLOCK_STATUS_CONTROL_OFS);
  // outputs trail the write edge
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      csc_d_r <= 8'h00;
    end else if (csc_wr) begin
      csc_d_r <= AVS_WRITEDATA_I[7:0];
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  wait_fetch_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("no answer");
  wait_single_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("long answer");
  read_upper_a: assert property (!AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0)
    else $error("upper read bits");
  mid_follow_a: assert property (csc_wr |-> ##3 (MID_SPEED_OSC_EN_O == csc_d_r[1]))
    else $error("mid enable");
  hs_follow_a: assert property (csc_wr |-> ##3 (HIGH_SPEED_OSC_EN_O == !csc_d_r[0]))
    else $error("hs enable");
  ls_run_a: assert property (LOW_SPEED_OSC_EN_O ==
    (SUBSYSTEM_USES_LOW_SPEED_O || INTERVAL_TIMER_LOW_SPEED_O)) else $error("low-speed run");
  main_mode_a: assert property (!(MAIN_CRYSTAL_OSC_EN_O && EXTERNAL_MAIN_CLOCK_O))
    else $error("main mode");
  sub_mode_a: assert property (!(SUB_CRYSTAL_OSC_EN_O && EXTERNAL_SUBCLOCK_O))
    else $error("sub mode");
  standby_gate_a: assert property (!STANDBY_I |=>
    (PERIPH_SUB_CLK_EN_O == RTC_SUB_CLK_EN_O) && (TIMER_SUB_CLK_EN_O == RTC_SUB_CLK_EN_O))
    else $error("sub gating");
endmodule

bind cpu_clock_source_switch clk_switch_checker #(.SYNC_CYCLES(SYNC_CYCLES)) chk (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .STANDBY_I(STANDBY_I),
  .HIGH_SPEED_OSC_EN_O(HIGH_SPEED_OSC_EN_O), .MID_SPEED_OSC_EN_O(MID_SPEED_OSC_EN_O),
  .LOW_SPEED_OSC_EN_O(LOW_SPEED_OSC_EN_O), .MAIN_CRYSTAL_OSC_EN_O(MAIN_CRYSTAL_OSC_EN_O),
  .EXTERNAL_MAIN_CLOCK_O(EXTERNAL_MAIN_CLOCK_O), .SUB_CRYSTAL_OSC_EN_O(SUB_CRYSTAL_OSC_EN_O),
  .EXTERNAL_SUBCLOCK_O(EXTERNAL_SUBCLOCK_O),
  .SUBSYSTEM_USES_LOW_SPEED_O(SUBSYSTEM_USES_LOW_SPEED_O),
  .INTERVAL_TIMER_LOW_SPEED_O(INTERVAL_TIMER_LOW_SPEED_O), .RTC_SUB_CLK_EN_O(RTC_SUB_CLK_EN_O),
  .TIMER_SUB_CLK_EN_O(TIMER_SUB_CLK_EN_O), .PERIPH_SUB_CLK_EN_O(PERIPH_SUB_CLK_EN_O));

/* verif/main_xtal_model.sv */
// partner: main resonator ticks
`timescale 1ns/1ps
module main_xtal_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic tick_o
);
  // ------
  // ticks
  // ------
  logic [1:0] div_r;
  // stopped: no ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 2'h0;
      tick_o <= 1'b0;
    end else begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      tick_o <= run_i && (!slow_i || div_r == 2'h0);
    end
  end
endmodule

/* verif/tb_cpu_clock_source_switch.sv */
// testbench of the clock switch
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_cpu_clock_source_switch
  import clk_switch_pkg::*;
;
  // ------
  // signals
  // ------
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, standby = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h00, q;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  wire logic [31:0] rdata;
  wire logic [1:0] drive, src;
  wire logic waitreq, tick, hs_en, mid_en, ls_en, mx_en, mx_ext, gain, sx_en, sx_ext;
  wire logic sub_ls, it_ls, rtc_en, tmr_en, per_en;
  int n_errors = 0, cmp_count = 0;
  // addr, write data, readback
  logic [23:0] rows [12] = '{24'h14ff00, 24'h1cff00, 24'h00ff01, 24'h000000, 24'h10ff07,
    24'h18ff90, 24'h180000, 24'h0cfff7, 24'h0c0000, 24'h08ffc3, 24'h08c0c0, 24'h100707};
  logic [7:0] rstv [7] = '{SUBSYSTEM_CLOCK_SELECT_RST, SYSTEM_CLOCK_CONTROL_RST,
    CLOCK_STATUS_CONTROL_RST, CLOCK_MODE_CONTROL_RST, OSC_STAB_TIME_SELECT_RST, 8'h00,
    SUBCLOCK_SUPPLY_MODE_RST};
  always #12.5 clk = ~clk;
  cpu_clock_source_switch dut (.MCLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .MAIN_OSC_TICK_I(tick),
    .STANDBY_I(standby), .HIGH_SPEED_OSC_EN_O(hs_en), .MID_SPEED_OSC_EN_O(mid_en),
    .LOW_SPEED_OSC_EN_O(ls_en), .MAIN_CRYSTAL_OSC_EN_O(mx_en), .EXTERNAL_MAIN_CLOCK_O(mx_ext),
    .MAIN_OSC_HIGH_GAIN_O(gain), .SUB_CRYSTAL_OSC_EN_O(sx_en), .EXTERNAL_SUBCLOCK_O(sx_ext),
    .SUB_OSC_DRIVE_O(drive), .CPU_PERIPHERAL_CLOCK_SRC_O(src),
    .SUBSYSTEM_USES_LOW_SPEED_O(sub_ls), .INTERVAL_TIMER_LOW_SPEED_O(it_ls),
    .RTC_SUB_CLK_EN_O(rtc_en), .TIMER_SUB_CLK_EN_O(tmr_en), .PERIPH_SUB_CLK_EN_O(per_en));
  main_xtal_model xtal (.clk_i(clk), .rst_n_i(rst_n), .run_i(mx_en | mx_ext), .slow_i(slow),
    .tick_o(tick));
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic done(input string nm);
    $display("%s done", nm);
  endtask
  // one bus access
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] b);
    int n;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    if (n >= 20) begin
      n_errors++;
      $display("[ERR] bus answer expected 0 seen 1");
      close_out();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    int k;
    k = 0;
    do begin
      acc(1'b0, a, 8'h00, 4'hf);
      k++;
    end while ((q & m) !== v && k < 1500);
    if (k >= 1500) begin
      n_errors++;
      $display("[ERR] poll %h expected %h seen %h", a, v, q & m);
      close_out();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, 8'(i * 4), 8'h00, 4'hf);
      `CHK("reset value", rstv[i], q)
    end
    `CHK("hs enable", 1'b1, hs_en)
    done("reset");
    for (int i = 0; i < 12; i++) begin
      acc(1'b1, rows[i][23:16], rows[i][15:8], 4'hf);
      acc(1'b0, rows[i][23:16], 8'h00, 4'hf);
      `CHK("readback", rows[i][7:0], q)
    end
    done("table");
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'hc2, 4'hf);
    `CHK("mid enable", 1'b1, mid_en)
    acc(1'b1, SYSTEM_CLOCK_CONTROL_OFS, 8'h01, 4'hf);
    poll(SYSTEM_CLOCK_CONTROL_OFS, 8'h02, 8'h02);
    `CHK("source mid", 2'b01, src)
    acc(1'b1, SUBSYSTEM_CLOCK_SELECT_OFS, 8'h01, 4'hf);
    `CHK("low speed run", 2'b11, {ls_en, sub_ls})
    acc(1'b1, SYSTEM_CLOCK_CONTROL_OFS, 8'h41, 4'hf);
    poll(SYSTEM_CLOCK_CONTROL_OFS, 8'h80, 8'h80);
    `CHK("cpu status word", 8'hc3, q)
    `CHK("source sub", 2'b11, src)
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'hc0, 4'hf);
    `CHK("mid stopped", 1'b0, mid_en)
    acc(1'b1, SYSTEM_CLOCK_CONTROL_OFS, 8'h51, 4'hf);
    acc(1'b0, SYSTEM_CLOCK_CONTROL_OFS, 8'h00, 4'hf);
    `CHK("main select frozen", 8'hc3, q)
    acc(1'b1, SUBCLOCK_SUPPLY_MODE_OFS, 8'h90, 4'hf);
    standby <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("standby supply", 4'b0111, {per_en, tmr_en, rtc_en, it_ls})
    standby <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("periph back", 1'b1, per_en)
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'hc2, 4'hf);
    acc(1'b1, SYSTEM_CLOCK_CONTROL_OFS, 8'h01, 4'hf);
    poll(SYSTEM_CLOCK_CONTROL_OFS, 8'h80, 8'h00);
    `CHK("source back", 2'b01, src)
    done("low speed");
    // slow resonator
    slow <= 1'b1;
    acc(1'b1, CLOCK_MODE_CONTROL_OFS, 8'h41, 4'hf);
    acc(1'b1, OSC_STAB_TIME_SELECT_OFS, 8'h02, 4'hf);
    `CHK("gain, crystal held", 2'b10, {gain, mx_en})
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'h42, 4'hf);
    `CHK("crystal run", 2'b10, {mx_en, mx_ext})
    acc(1'b0, OSC_STAB_COUNTER_STATUS_OFS, 8'h00, 4'hf);
    `CHK("count early", 8'h00, q)
    poll(OSC_STAB_COUNTER_STATUS_OFS, 8'hff, 8'he0);
    acc(1'b1, SYSTEM_CLOCK_CONTROL_OFS, 8'h11, 4'hf);
    poll(SYSTEM_CLOCK_CONTROL_OFS, 8'h20, 8'h20);
    `CHK("main status word", 8'h33, q)
    `CHK("source main", 2'b10, src)
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'h40, 4'hf);
    acc(1'b1, CLOCK_MODE_CONTROL_OFS, 8'hd6, 4'hf);
    `CHK("external main", 2'b01, {mx_en, mx_ext})
    acc(1'b0, OSC_STAB_COUNTER_STATUS_OFS, 8'h00, 4'hf);
    `CHK("no wait external", 8'h00, q)
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'h00, 4'hf);
    `CHK("sub crystal", 4'b1011, {sx_en, sx_ext, drive})
    acc(1'b1, CLOCK_MODE_CONTROL_OFS, 8'hf0, 4'hf);
    `CHK("external sub", 4'b0100, {sx_en, sx_ext, drive})
    acc(1'b1, CLOCK_STATUS_CONTROL_OFS, 8'h01, 4'hf);
    `CHK("hs stopped", 1'b0, hs_en)
    acc(1'b1, SUBSYSTEM_CLOCK_SELECT_OFS, 8'h00, 4'he);
    acc(1'b0, SUBSYSTEM_CLOCK_SELECT_OFS, 8'h00, 4'hf);
    `CHK("lane refused", 8'h01, q)
    done("main and sub");
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b0, CLOCK_STATUS_CONTROL_OFS, 8'h00, 4'hf);
    `CHK("csc after reset", CLOCK_STATUS_CONTROL_RST, q)
    `CHK("source after reset", 2'b00, src)
    done("second reset");
    close_out();
  end
endmodule
